// ### hw/wesr_pkg.sv
// Constants for the wake event status and ready block.
// Assumes a host on a plain strobe port; word addresses equal byte offsets.
package wesr_pkg;
  localparam int WESR_AW = 8;
  localparam logic [7:0] WESR_OFF_BYTE_TEST = 8'h64;
  localparam logic [7:0] WESR_OFF_PWR_CTRL = 8'h84;
  localparam logic [31:0] WESR_BYTE_TEST_VAL = 32'h87654321;
  localparam int WESR_BIT_READY = 0;
  localparam int WESR_BIT_OUT_EN = 1;
  localparam int WESR_BIT_POL = 2;
  localparam int WESR_BIT_PULSE = 3;
  localparam int WESR_BIT_CAUSE_LO = 4;
  localparam int WESR_BIT_DRV_TYPE = 6;
  localparam int WESR_BIT_ENERGY_DETECT_ENABLE = 8;
  localparam int WESR_BIT_WF_EN = 9;
  localparam int WESR_BIT_PS_LO = 12;
  localparam logic [1:0] WESR_PS_NORMAL = 2'h0;
  localparam logic [1:0] WESR_PS_RESERVED = 2'h3;
  localparam int WESR_CLK_MHZ = 250;
  localparam int WESR_PULSE_MS = 50;
  localparam int WESR_PULSE_CYC = WESR_PULSE_MS * 1000 * WESR_CLK_MHZ;
  localparam int WESR_READY_CYC = 64;
endpackage : wesr_pkg

// ### hw/wesr_core.sv
// Wake cause status, wake event output shaping and device ready flag.
// Assumes event sources are pulses or levels on mclk; ready delay is a parameter.
`timescale 1ns/1ps
`default_nettype none
module wesr_core
  import wesr_pkg::*;
#(
  parameter int PULSE_CYC = WESR_PULSE_CYC,
  parameter int READY_CYC = WESR_READY_CYC
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [WESR_AW-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rdata,
  input wire logic energy_pend_async,
  input wire logic wake_frame_pend_async,
  output logic wake_event_out,
  output logic wake_event_oe,
  output logic wake_event_interrupt,
  output logic [1:0] power_state
);

  typedef enum logic [1:0] {WESR_IDLE, WESR_PULSE, WESR_HOLD} wesr_out_t;

  logic [1:0] wake_cause_status_reg;
  logic wake_output_pulse_select_reg;
  logic wake_output_polarity_reg;
  logic wake_output_enable_reg;
  logic wake_output_driver_type_reg;
  logic energy_detect_enable_reg;
  logic wake_frame_enable_reg;
  logic [1:0] power_state_select_reg;
  logic ready_reg;
  logic [15:0] ready_cnt_reg;
  logic [1:0] ed_sync_reg;
  logic [1:0] wf_sync_reg;
  logic ed_seen_reg;
  logic wf_seen_reg;
  logic [31:0] pulse_cnt_reg;
  wesr_out_t out_state_reg;
  logic active_reg;
  logic ed_pend;
  logic wf_pend;
  logic ed_evt;
  logic wf_evt;
  logic det;
  logic wr_ctrl;
  logic wr_wake;
  logic [1:0] clr_mask;
  logic en_drop;

  // Register decode helper, used for both read and write paths
  function automatic logic hit(input logic [WESR_AW-1:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // Two-flop synchronisers for external event sources
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ed_sync_reg <= 2'h0;
      wf_sync_reg <= 2'h0;
    end
    else
    begin
      ed_sync_reg <= {ed_sync_reg[0], energy_pend_async};
      wf_sync_reg <= {wf_sync_reg[0], wake_frame_pend_async};
    end
  end

  // Rising-edge detection on gated, synchronised sources
  assign ed_pend = ed_sync_reg[1] & energy_detect_enable_reg;
  assign wf_pend = wf_sync_reg[1] & wake_frame_enable_reg;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ed_seen_reg <= 1'b0;
      wf_seen_reg <= 1'b0;
    end
    else
    begin
      ed_seen_reg <= ed_pend;
      wf_seen_reg <= wf_pend;
    end
  end
  assign ed_evt = ed_pend & ~ed_seen_reg;
  assign wf_evt = wf_pend & ~wf_seen_reg;
  assign det = ed_evt | wf_evt;

  assign wr_ctrl = wr_stb & hit(addr, WESR_OFF_PWR_CTRL);
  assign wr_wake = wr_stb & hit(addr, WESR_OFF_BYTE_TEST);
  // Clear mask only honoured in normal state with ready set
  assign clr_mask = (wr_ctrl && ready_reg && power_state_select_reg == WESR_PS_NORMAL) ?
    wdata[WESR_BIT_CAUSE_LO +: 2] : 2'h0;

  // Wake cause: set wins over clear, pending source blocks clear
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      wake_cause_status_reg <= 2'h0;
    else
    begin
      wake_cause_status_reg[0] <= ed_evt | ed_pend |
        (wake_cause_status_reg[0] & ~clr_mask[0]);
      wake_cause_status_reg[1] <= wf_evt | wf_pend |
        (wake_cause_status_reg[1] & ~clr_mask[1]);
    end
  end

  // Writable configuration fields
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wake_output_pulse_select_reg <= 1'b0;
      wake_output_polarity_reg <= 1'b0;
      wake_output_enable_reg <= 1'b0;
      wake_output_driver_type_reg <= 1'b0;
      energy_detect_enable_reg <= 1'b0;
      wake_frame_enable_reg <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      wake_output_pulse_select_reg <= wdata[WESR_BIT_PULSE];
      wake_output_polarity_reg <= wdata[WESR_BIT_POL];
      wake_output_enable_reg <= wdata[WESR_BIT_OUT_EN];
      wake_output_driver_type_reg <= wdata[WESR_BIT_DRV_TYPE];
      energy_detect_enable_reg <= wdata[WESR_BIT_ENERGY_DETECT_ENABLE];
      wake_frame_enable_reg <= wdata[WESR_BIT_WF_EN];
    end
  end

  // Power state select; reserved code is not accepted, byte test write wakes
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      power_state_select_reg <= WESR_PS_NORMAL;
    else if (wr_wake && power_state_select_reg != WESR_PS_NORMAL)
      power_state_select_reg <= WESR_PS_NORMAL;
    else if (wr_ctrl && wdata[WESR_BIT_PS_LO +: 2] != WESR_PS_RESERVED)
      power_state_select_reg <= wdata[WESR_BIT_PS_LO +: 2];
    else if (det && power_state_select_reg != WESR_PS_NORMAL)
      power_state_select_reg <= WESR_PS_NORMAL;
  end

  // Ready: drops in reduced power, sets after a settle count back in normal
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ready_reg <= 1'b0;
      ready_cnt_reg <= 16'h0000;
    end
    else if (power_state_select_reg != WESR_PS_NORMAL)
    begin
      ready_reg <= 1'b0;
      ready_cnt_reg <= 16'h0000;
    end
    else if (!ready_reg)
    begin
      if (ready_cnt_reg == 16'(READY_CYC - 1))
        ready_reg <= 1'b1;
      else
        ready_cnt_reg <= ready_cnt_reg + 16'h0001;
    end
  end

  // Output activity state machine: pulse timer or static hold
  assign en_drop = ~(energy_detect_enable_reg | wake_frame_enable_reg);
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_state_reg <= WESR_IDLE;
      pulse_cnt_reg <= 32'h00000000;
    end
    else if (det)
    begin
      out_state_reg <= wake_output_pulse_select_reg ? WESR_PULSE : WESR_HOLD;
      pulse_cnt_reg <= 32'h00000000;
    end
    else if (wake_cause_status_reg == 2'h0 || en_drop)
      out_state_reg <= WESR_IDLE;
    else
      unique case (out_state_reg)
        WESR_IDLE: out_state_reg <= WESR_IDLE;
        WESR_PULSE:
        begin
          if (pulse_cnt_reg == 32'(PULSE_CYC - 1))
            out_state_reg <= WESR_IDLE;
          else
            pulse_cnt_reg <= pulse_cnt_reg + 32'h00000001;
        end
        WESR_HOLD: out_state_reg <= WESR_HOLD;
      endcase
  end
  assign active_reg = (out_state_reg != WESR_IDLE);

  // Pin shaping: enable, driver type, polarity
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wake_event_out <= 1'b0;
      wake_event_oe <= 1'b0;
    end
    else if (!wake_output_driver_type_reg)
    begin
      wake_event_out <= 1'b0;
      wake_event_oe <= active_reg & wake_output_enable_reg;
    end
    else
    begin
      wake_event_oe <= 1'b1;
      wake_event_out <= (active_reg & wake_output_enable_reg) ~^ wake_output_polarity_reg;
    end
  end

  // Interrupt independent of the output enable
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wake_event_interrupt <= 1'b0;
      power_state <= WESR_PS_NORMAL;
    end
    else
    begin
      wake_event_interrupt <= |wake_cause_status_reg;
      power_state <= power_state_select_reg;
    end
  end

  // Read data, one cycle after the strobe, answered in every mode
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= 32'h00000000;
    else if (rd_stb && hit(addr, WESR_OFF_PWR_CTRL))
      rdata <= {18'h0, power_state_select_reg, 2'h0, wake_frame_enable_reg, energy_detect_enable_reg,
        1'b0, wake_output_driver_type_reg, wake_cause_status_reg, wake_output_pulse_select_reg,
        wake_output_polarity_reg, wake_output_enable_reg, ready_reg};
    else if (rd_stb && hit(addr, WESR_OFF_BYTE_TEST))
      rdata <= WESR_BYTE_TEST_VAL;
    else
      rdata <= 32'h00000000;
  end

  // Checks
  property p_clr_blocked;
    @(posedge mclk) disable iff (!rst_n)
    (wr_ctrl && !ready_reg && wake_cause_status_reg[0]) |=> wake_cause_status_reg[0];
  endproperty
  a_clr_blocked: assert property (p_clr_blocked) else $error("cause cleared while not ready");
  property p_clr_ok;
    @(posedge mclk) disable iff (!rst_n)
    (clr_mask[1] && !wf_pend && !wf_evt) |=> !wake_cause_status_reg[1];
  endproperty
  a_clr_ok: assert property (p_clr_ok) else $error("cause bit not cleared");
  property p_pend_hold;
    @(posedge mclk) disable iff (!rst_n) ed_pend |=> wake_cause_status_reg[0];
  endproperty
  a_pend_hold: assert property (p_pend_hold) else $error("cause cleared while pending");
  property p_od_low;
    @(posedge mclk) disable iff (!rst_n) (!wake_output_driver_type_reg) |=> !wake_event_out;
  endproperty
  a_od_low: assert property (p_od_low) else $error("open drain drives high");
  property p_oe_off;
    @(posedge mclk) disable iff (!rst_n)
    (!wake_output_enable_reg && !wake_output_driver_type_reg) |=> !wake_event_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("output driven while disabled");
  property p_pp_pol;
    @(posedge mclk) disable iff (!rst_n)
    (wake_output_driver_type_reg && !(active_reg && wake_output_enable_reg))
      |=> wake_event_out == !$past(wake_output_polarity_reg);
  endproperty
  a_pp_pol: assert property (p_pp_pol) else $error("inactive level wrong");
  property p_int;
    @(posedge mclk) disable iff (!rst_n) (|wake_cause_status_reg) |=> wake_event_interrupt;
  endproperty
  a_int: assert property (p_int) else $error("interrupt missing");
  property p_det;
    @(posedge mclk) disable iff (!rst_n) det |=> active_reg;
  endproperty
  a_det: assert property (p_det) else $error("detection not shown");
  property p_wake;
    @(posedge mclk) disable iff (!rst_n) wr_wake |=> power_state_select_reg == WESR_PS_NORMAL;
  endproperty
  a_wake: assert property (p_wake) else $error("byte test write did not wake");

  // Ready, state select, pulse timing, hold, clear, restart and read path checks
  property p_ready_drop;
    @(posedge mclk) disable iff (!rst_n)
    (power_state_select_reg != WESR_PS_NORMAL) |=> !ready_reg;
  endproperty
  a_ready_drop: assert property (p_ready_drop) else $error("ready kept in reduced power");
  property p_reserved;
    @(posedge mclk) disable iff (!rst_n)
    (wr_ctrl && wdata[WESR_BIT_PS_LO +: 2] == WESR_PS_RESERVED) |=> power_state_select_reg != WESR_PS_RESERVED;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved power state taken");
  property p_pulse_end;
    @(posedge mclk) disable iff (!rst_n)
    (out_state_reg == WESR_PULSE && pulse_cnt_reg == 32'(PULSE_CYC - 1) && !det) |=> out_state_reg == WESR_IDLE;
  endproperty
  a_pulse_end: assert property (p_pulse_end) else $error("pulse did not end");
  property p_hold_stays;
    @(posedge mclk) disable iff (!rst_n)
    (out_state_reg == WESR_HOLD && !det && (|wake_cause_status_reg) && !en_drop) |=> out_state_reg == WESR_HOLD;
  endproperty
  a_hold_stays: assert property (p_hold_stays) else $error("static output dropped");
  property p_clear_drop;
    @(posedge mclk) disable iff (!rst_n)
    (wake_cause_status_reg == 2'h0 && !det) |=> !active_reg;
  endproperty
  a_clear_drop: assert property (p_clear_drop) else $error("output active with no cause");
  property p_restart;
    @(posedge mclk) disable iff (!rst_n)
    det |=> pulse_cnt_reg == 32'h00000000;
  endproperty
  a_restart: assert property (p_restart) else $error("pulse timer not restarted");
  property p_not_ready_keep;
    @(posedge mclk) disable iff (!rst_n)
    (!ready_reg && wake_cause_status_reg[1]) |=> wake_cause_status_reg[1];
  endproperty
  a_not_ready_keep: assert property (p_not_ready_keep) else $error("cause lost while not ready");
  property p_rd_answer;
    @(posedge mclk) disable iff (!rst_n)
    (rd_stb && addr == WESR_OFF_PWR_CTRL) |=> rdata[WESR_BIT_READY] == $past(ready_reg);
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("power control read wrong");
  property p_pp_active;
    @(posedge mclk) disable iff (!rst_n)
    (wake_output_driver_type_reg && active_reg && wake_output_enable_reg)
      |=> wake_event_out == $past(wake_output_polarity_reg);
  endproperty
  a_pp_active: assert property (p_pp_active) else $error("active level wrong");
  c_pulse: cover property (@(posedge mclk) disable iff (!rst_n) out_state_reg == WESR_PULSE);
  c_hold: cover property (@(posedge mclk) disable iff (!rst_n) out_state_reg == WESR_HOLD);
  c_clear: cover property (@(posedge mclk) disable iff (!rst_n) |clr_mask);
  c_wake: cover property (@(posedge mclk) disable iff (!rst_n)
    wr_wake && power_state_select_reg != WESR_PS_NORMAL);
  c_restart: cover property (@(posedge mclk) disable iff (!rst_n) det && out_state_reg == WESR_PULSE);
endmodule : wesr_core
`default_nettype wire

// ### verif/wesr_wake_sink.sv
// System wake input that listens to the wake event pin.
// Assumes a pull-up on the wire; the bench says whether the driver is push-pull.
`timescale 1ns/1ps
`default_nettype none
module wesr_wake_sink
(
  input wire logic wake_event_out,
  input wire logic wake_event_oe,
  input wire logic push_pull,
  output logic pin_level
);
  // Open-drain pulls low when enabled, released wire floats up to the pull-up
  assign pin_level = wake_event_oe ? (push_pull ? wake_event_out : 1'b0) : 1'b1;
endmodule : wesr_wake_sink
`default_nettype wire

// ### verif/tb_wake_event_status_and_ready.sv
// Self-checking bench for the wake event status and ready block.
// Assumes short pulse and ready counts set through the core's parameters.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module tb_wake_event_status_and_ready import wesr_pkg::*; ();
  logic mclk, rst_n, rd_stb, wr_stb, efp, wfp, pp, pin, w_out, w_oe, w_irq;
  logic [WESR_AW-1:0] addr;
  logic [31:0] wdata, rdata;
  logic [1:0] pstate;
  int fail_count, n_compared;
  localparam logic [7:0] PC = WESR_OFF_PWR_CTRL;

  wesr_core #(.PULSE_CYC(100), .READY_CYC(4)) dut (.mclk(mclk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .energy_pend_async(efp),
    .wake_frame_pend_async(wfp), .wake_event_out(w_out), .wake_event_oe(w_oe),
    .wake_event_interrupt(w_irq), .power_state(pstate));
  wesr_wake_sink sink (.wake_event_out(w_out), .wake_event_oe(w_oe), .push_pull(pp), .pin_level(pin));

  // Clock at 4 ns period
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic stop_test();
    if (fail_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask : wr

  // One-cycle read strobe, data taken in the following cycle
  task automatic rd_raw(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_raw

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd_raw(a, d);
    `CHK("rdata", e, d)
  endtask : rd

  // Config write that also tells the sink the driver type
  task automatic cfg(input logic [31:0] d);
    pp = d[WESR_BIT_DRV_TYPE];
    wr(PC, d);
  endtask : cfg

  // Wake frame source pending for a few cycles, then settle
  task automatic ev();
    @(posedge mclk);
    wfp <= 1'b1;
    repeat (3) @(posedge mclk);
    wfp <= 1'b0;
    repeat (6) @(posedge mclk);
    #1;
  endtask : ev

  // Bounded poll of the ready flag
  task automatic wait_rdy();
    logic [31:0] d;
    int i;
    d = '0;
    i = 0;
    while (d[0] !== 1'b1 && i < 20)
    begin
      rd_raw(PC, d);
      i++;
    end
    if (d[0] !== 1'b1)
    begin
      fail_count++;
      stop_test();
    end
  endtask : wait_rdy

  // Watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    stop_test();
  end

  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    rd_stb = 1'b0;
    wr_stb = 1'b0;
    addr = '0;
    wdata = '0;
    efp = 1'b0;
    wfp = 1'b0;
    pp = 1'b0;
    fail_count = 0;
    n_compared = 0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    rd(PC, 32'h0);
    wait_rdy();
    rd(PC, 32'h1);
    rd(WESR_OFF_BYTE_TEST, WESR_BYTE_TEST_VAL);
    // Push-pull, active high, static, both sources enabled
    cfg(32'h346);
    rd(PC, 32'h347);
    ev();
    rd(PC, 32'h367);
    wr(PC, 32'h346);
    repeat (120) @(posedge mclk);
    rd(PC, 32'h367);
    `CHK("pin", 1'b1, pin)
    `CHK("irq", 1'b1, w_irq)
    @(posedge mclk);
    efp <= 1'b1;
    repeat (8) @(posedge mclk);
    rd(PC, 32'h377);
    wr(PC, 32'h376);
    rd(PC, 32'h357);
    @(posedge mclk);
    efp <= 1'b0;
    repeat (6) @(posedge mclk);
    wr(PC, 32'h356);
    rd(PC, 32'h347);
    `CHK("pin", 1'b0, pin)
    `CHK("irq", 1'b0, w_irq)
    // Pulse mode: active, then inactive after the pulse while cause stays
    cfg(32'h34E);
    ev();
    `CHK("pin", 1'b1, pin)
    repeat (50) @(posedge mclk);
    ev();
    repeat (60) @(posedge mclk);
    #1;
    `CHK("pin", 1'b1, pin)
    repeat (50) @(posedge mclk);
    #1;
    `CHK("pin", 1'b0, pin)
    `CHK("irq", 1'b1, w_irq)
    cfg(32'h37E);
    // Open-drain with polarity one still pulls low
    cfg(32'h306);
    ev();
    `CHK("pin", 1'b0, pin)
    cfg(32'h336);
    repeat (3) @(posedge mclk);
    #1;
    `CHK("pin", 1'b1, pin)
    // Output disabled: interrupt still raised, pin left alone
    cfg(32'h304);
    ev();
    `CHK("irq", 1'b1, w_irq)
    `CHK("oe", 1'b0, w_oe)
    cfg(32'h334);
    // Reduced modes, clear held off and cause kept, woken by a byte test write
    for (int s = 1; s < 3; s++)
    begin
      ev();
      wr(PC, 32'h300 | (32'(s) << 12));
      repeat (2) @(posedge mclk);
      #1;
      `CHK("state", 2'(s), pstate)
      wr(PC, 32'h330 | (32'(s) << 12));
      wr(WESR_OFF_BYTE_TEST, 32'h0);
      wait_rdy();
      `CHK("state", 2'h0, pstate)
      rd(PC, 32'h321);
      wr(PC, 32'h330);
    end
    wr(PC, 32'h3300);
    repeat (2) @(posedge mclk);
    #1;
    `CHK("state", 2'h0, pstate)
    stop_test();
  end
endmodule : tb_wake_event_status_and_ready
`default_nettype wire
